// ### hw/tuner_pkg.sv
// Shared constants for the tuner two-wire port and its bus master.
package tuner_pkg;
  // Bus address: seven-bit base, strap lands in the lowest address bit.
  localparam logic [6:0] BASE_ADDR  = 7'h60;
  localparam int         ADDR_BITS  = 7;
  localparam int         BYTE_BITS  = 8;
  localparam int         ACK_SLOT   = 8;
  localparam int         CNT_W      = 4;
  // Register pointer values of the test and status registers.
  localparam logic [7:0] TEST_IDX   = 8'h0b;
  localparam logic [7:0] STAT1_IDX  = 8'h0c;
  localparam logic [7:0] STAT2_IDX  = 8'h0d;
  localparam logic [7:0] TEST_RESET = 8'h00;
  // Test register fields.
  localparam int CPT_HI  = 7;
  localparam int CPT_LO  = 5;
  localparam int FAST_LOCK_BIT = 3;
  localparam int REFSEL_HI = 2;
  localparam int REFSEL_LO = 0;
  // Charge-pump test codes.
  localparam logic [2:0] CP_NORMAL    = 3'h0;
  localparam logic [2:0] CP_XTAL_PATH = 3'h1;
  localparam logic [2:0] CP_BOTH      = 3'h4;
  localparam logic [2:0] CP_SOURCE    = 3'h5;
  localparam logic [2:0] CP_SINK      = 3'h6;
  localparam logic [2:0] CP_HIGH_Z    = 3'h7;
  localparam logic [2:0] REFSEL_NORMAL = 3'h0;
  // First status byte fields.
  localparam int POR_BIT  = 7;
  localparam int ASUC_BIT = 6;
  localparam int ADONE_BIT = 5;
  localparam int LOCK_BIT = 4;
  // Second status byte fields.
  localparam int BAND_HI = 7;
  localparam int BAND_LO = 3;
  localparam int CODE_HI = 2;
  localparam int CODE_LO = 0;
  // Master register map on APB.
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] TXD_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] RXD_OFS    = 8'h0c;
  // Command codes written to the command register.
  localparam logic [2:0] OP_START = 3'h1;
  localparam logic [2:0] OP_STOP  = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_READ  = 3'h4;
  localparam int OP_HI    = 2;
  localparam int NACK_BIT = 3;
  localparam int BUSY_BIT = 0;
  localparam int GOTNACK_BIT = 1;
  // Timing: fastest bus clock period and system clock period.
  localparam int CLK_NS      = 40;
  localparam int SCL_MIN_NS  = 2500;
  localparam int QTR_CYC     = (SCL_MIN_NS / 4 + CLK_NS - 1) / CLK_NS;
endpackage

// ### hw/tuner_link_if.sv
// Two-wire bus between the master and the tuner port, with pull-ups.
`timescale 1ns/1ps
interface tuner_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic msda_o;
  logic msda_oe_n;
  logic dsda_o;
  logic dsda_oe_n;
  logic scl;
  logic sda;

  // Open-drain wires: any enabled low driver wins, otherwise pulled high.
  assign scl = (!scl_oe_n && !scl_o) ? 1'b0 : 1'b1;
  assign sda = ((!msda_oe_n && !msda_o) || (!dsda_oe_n && !dsda_o))
               ? 1'b0 : 1'b1;

  modport master (output scl_o, output scl_oe_n, output msda_o,
                  output msda_oe_n, input scl, input sda);
  modport device (output dsda_o, output dsda_oe_n, input scl, input sda);
endinterface

// ### hw/tuner_slave.sv
// Two-wire slave port with the test and status registers of the tuner.
//
// Functional notes
// [RULE1] Charge-pump test field selects test modes.
// [RULE2] Controller sets fast-lock bit after power-up.
// [RULE3] Reference output select normal at zero.
// [RULE4] Power-cycle flag clears after read then stop.
// [RULE5] Status reports autoselect success.
// [RULE6] Status reports autoselect inactive.
// [RULE7] Lock flag valid only with fast lock.
// [RULE8] Second status: band and converter code.
// [RULE9] Slave on master-clocked bus, 400kHz max.
// [RULE10] Nine clocks per byte, ack last.
// [RULE11] Data changes during clock high are controls.
// [RULE12] Master frames with start and stop.
// [RULE13] Acknowledge holds data low through ninth pulse.
// [RULE14] Not-acknowledge leaves data high.
// [RULE15] Seven-bit address then direction bit.
// [RULE16] Strap chooses C0/C1 or C2/C3.
// [RULE17] Match on own address acknowledges.
// [RULE18] Write: pointer, then auto-incremented data.
// [RULE19] Write stays open until stop.
// [RULE20] Read after pointer write and repeated start.
// [RULE21] Master acks to continue, nacks to end.
// [RULE22] Master retries after unacknowledged transfer; tuner_master only flags the nack in its status register.
// [RULE23] Foreign address left unacknowledged.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module tuner_slave (
  // System
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bus pins
  tuner_link_if.device     link,
  // Address strap
  input  wire logic        addr_strap,
  // Analog status
  input  wire logic        autoselect_success,
  input  wire logic        autoselect_done,
  input  wire logic        pll_lock_flag,
  input  wire logic [4:0]  oscillator_band_readback,
  input  wire logic [2:0]  tune_code,
  // Test register fields
  output logic [2:0]       charge_pump_test_select,
  output logic             fast_lock_enable,
  output logic [2:0]       reference_output_select,
  // Writes to registers held elsewhere
  output logic             cfg_wr_valid,
  output logic [7:0]       cfg_wr_index,
  output logic [7:0]       cfg_wr_data
);
  typedef enum logic [5:0] {
    S_IDLE   = 6'h01,
    S_ADDR   = 6'h02,
    S_RX     = 6'h04,
    S_ACKOUT = 6'h08,
    S_TX     = 6'h10,
    S_ACKIN  = 6'h20
  } slave_state_t;

  localparam int STAT_W = 11;

  slave_state_t            state_reg;
  logic [1:0]              scl_sync_reg;
  logic [1:0]              sda_sync_reg;
  logic                    scl_prev_reg;
  logic                    sda_prev_reg;
  logic [STAT_W-1:0]       stat_meta_reg;
  logic [STAT_W-1:0]       stat_sync_reg;
  logic                    strap_meta_reg;
  logic                    strap_reg;
  logic [7:0]              shift_reg;
  logic [7:0]              tx_reg;
  logic [tuner_pkg::CNT_W-1:0] bit_cnt_reg;
  logic                    first_byte_reg;
  logic                    read_dir_reg;
  logic                    acked_reg;
  logic [7:0]              ptr_reg;
  logic                    drive_low_reg;
  logic                    por_reg;
  logic                    stat1_read_reg;
  logic [7:0]              test_reg;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_seen;
  logic                    stop_seen;
  logic                    addr_match;
  logic                    rx_data_done;
  logic [7:0]              stat1_byte;
  logic [7:0]              stat2_byte;
  logic [7:0]              rd_byte;

  // Pins and analog levels come from other domains: two flops first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_reg  <= 2'h3;
      sda_sync_reg  <= 2'h3;
      scl_prev_reg  <= 1'b1;
      sda_prev_reg  <= 1'b1;
      stat_meta_reg <= '0;
      stat_sync_reg <= '0;
    end else begin
      scl_sync_reg  <= {scl_sync_reg[0], link.scl};
      sda_sync_reg  <= {sda_sync_reg[0], link.sda};
      scl_prev_reg  <= scl_sync_reg[1];
      sda_prev_reg  <= sda_sync_reg[1];
      stat_meta_reg <= {autoselect_success, autoselect_done, pll_lock_flag,
                        oscillator_band_readback, tune_code};
      stat_sync_reg <= stat_meta_reg;
    end
  end

  assign scl_rise   = scl_sync_reg[1] && !scl_prev_reg;
  assign scl_fall   = !scl_sync_reg[1] && scl_prev_reg;
  // Data moving while the clock stays high is a control, not a bit.
  assign start_seen = scl_sync_reg[1] && scl_prev_reg &&
                      !sda_sync_reg[1] && sda_prev_reg; // [RULE11] [RULE12]
  assign stop_seen  = scl_sync_reg[1] && scl_prev_reg &&
                      sda_sync_reg[1] && !sda_prev_reg; // [RULE11] [RULE12]

  // The strap is a pin like any other: two flops before the compare.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta_reg <= 1'b0;
      strap_reg      <= 1'b0;
    end else begin
      strap_meta_reg <= addr_strap;
      strap_reg      <= strap_meta_reg;
    end
  end

  assign addr_match = shift_reg[7:1] ==
    {tuner_pkg::BASE_ADDR[6:1], strap_reg}; // [RULE15] [RULE16]

  // Status bytes; lock is only meaningful with fast lock on.
  always_comb begin
    stat1_byte = '0;
    stat1_byte[tuner_pkg::POR_BIT]   = por_reg; // [RULE4]
    stat1_byte[tuner_pkg::ASUC_BIT]  = stat_sync_reg[10]; // [RULE5]
    stat1_byte[tuner_pkg::ADONE_BIT] = stat_sync_reg[9]; // [RULE6]
    stat1_byte[tuner_pkg::LOCK_BIT]  = stat_sync_reg[8] &&
                                       fast_lock_enable; // [RULE7]
    stat2_byte = '0;
    stat2_byte[tuner_pkg::BAND_HI:tuner_pkg::BAND_LO] =
      stat_sync_reg[7:3]; // [RULE8]
    stat2_byte[tuner_pkg::CODE_HI:tuner_pkg::CODE_LO] =
      stat_sync_reg[2:0]; // [RULE8]
  end

  // Registers that live in other blocks read back as zero here.
  always_comb begin
    unique case (ptr_reg)
      tuner_pkg::TEST_IDX:  rd_byte = test_reg;
      tuner_pkg::STAT1_IDX: rd_byte = stat1_byte;
      tuner_pkg::STAT2_IDX: rd_byte = stat2_byte;
      default:              rd_byte = 8'h00;
    endcase
  end

  assign rx_data_done = scl_fall && (state_reg == S_RX) &&
                        (bit_cnt_reg == tuner_pkg::ACK_SLOT) &&
                        !first_byte_reg;

  // Byte engine: bits are taken on clock rise, the line changes on fall.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= S_IDLE;
      shift_reg      <= '0;
      tx_reg         <= '0;
      bit_cnt_reg    <= '0;
      first_byte_reg <= 1'b0;
      read_dir_reg   <= 1'b0;
      acked_reg      <= 1'b0;
      ptr_reg        <= '0;
      drive_low_reg  <= 1'b0;
    end else if (start_seen) begin
      // A start is honoured in any state, so a repeated start works.
      state_reg     <= S_ADDR; // [RULE17]
      bit_cnt_reg   <= '0;
      drive_low_reg <= 1'b0;
    end else if (stop_seen) begin
      state_reg     <= S_IDLE; // [RULE19]
      drive_low_reg <= 1'b0;
    end else if (scl_rise) begin
      unique case (state_reg)
        S_ADDR, S_RX: begin
          shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]}; // [RULE18]
          bit_cnt_reg <= bit_cnt_reg + 1'b1; // [RULE10]
        end
        S_TX:    bit_cnt_reg <= bit_cnt_reg + 1'b1; // [RULE10]
        S_ACKIN: acked_reg   <= !sda_sync_reg[1]; // [RULE21]
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_reg)
        S_ADDR: if (bit_cnt_reg == tuner_pkg::ACK_SLOT) begin
          if (addr_match) begin
            state_reg      <= S_ACKOUT;
            drive_low_reg  <= 1'b1; // [RULE13] [RULE17]
            read_dir_reg   <= shift_reg[0]; // [RULE15]
            first_byte_reg <= !shift_reg[0];
          end else begin
            state_reg <= S_IDLE; // [RULE23]
          end
        end
        S_RX: if (bit_cnt_reg == tuner_pkg::ACK_SLOT) begin
          state_reg      <= S_ACKOUT;
          drive_low_reg  <= 1'b1; // [RULE13] [RULE18]
          first_byte_reg <= 1'b0;
          ptr_reg        <= first_byte_reg ? shift_reg
                                           : ptr_reg + 1'b1; // [RULE18]
        end
        S_ACKOUT: begin
          bit_cnt_reg <= '0;
          if (read_dir_reg) begin
            state_reg     <= S_TX; // [RULE20]
            tx_reg        <= {rd_byte[6:0], 1'b0};
            drive_low_reg <= !rd_byte[7];
            ptr_reg       <= ptr_reg + 1'b1;
          end else begin
            state_reg     <= S_RX; // [RULE19]
            drive_low_reg <= 1'b0;
          end
        end
        S_TX: if (bit_cnt_reg == tuner_pkg::ACK_SLOT) begin
          state_reg     <= S_ACKIN;
          drive_low_reg <= 1'b0; // [RULE14]
        end else begin
          tx_reg        <= {tx_reg[6:0], 1'b0};
          drive_low_reg <= !tx_reg[7]; // [RULE20]
        end
        S_ACKIN: if (acked_reg) begin
          state_reg     <= S_TX; // [RULE21]
          bit_cnt_reg   <= '0;
          tx_reg        <= {rd_byte[6:0], 1'b0};
          drive_low_reg <= !rd_byte[7];
          ptr_reg       <= ptr_reg + 1'b1;
        end else begin
          state_reg <= S_IDLE; // [RULE21]
        end
        default: ;
      endcase
    end
  end

  // Power-cycle flag: only reset sets it, so the clear has no race.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_reg        <= 1'b1; // [RULE4]
      stat1_read_reg <= 1'b0;
    end else if (stop_seen) begin
      stat1_read_reg <= 1'b0;
      if (stat1_read_reg) begin
        por_reg <= 1'b0; // [RULE4]
      end
    end else if (scl_fall && read_dir_reg &&
                 ptr_reg == tuner_pkg::STAT1_IDX &&
                 ((state_reg == S_ACKOUT) ||
                  (state_reg == S_ACKIN && acked_reg))) begin
      stat1_read_reg <= 1'b1;
    end
  end

  // Test register; status registers ignore writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_reg     <= tuner_pkg::TEST_RESET; // [RULE2]
      cfg_wr_valid <= 1'b0;
      cfg_wr_index <= '0;
      cfg_wr_data  <= '0;
    end else begin
      cfg_wr_valid <= 1'b0;
      if (rx_data_done) begin
        if (ptr_reg == tuner_pkg::TEST_IDX) begin
          test_reg <= shift_reg; // [RULE1] [RULE3]
        end else if (ptr_reg != tuner_pkg::STAT1_IDX &&
                     ptr_reg != tuner_pkg::STAT2_IDX) begin
          cfg_wr_valid <= 1'b1;
          cfg_wr_index <= ptr_reg;
          cfg_wr_data  <= shift_reg;
        end
      end
    end
  end

  assign charge_pump_test_select =
    test_reg[tuner_pkg::CPT_HI:tuner_pkg::CPT_LO]; // [RULE1]
  assign fast_lock_enable = test_reg[tuner_pkg::FAST_LOCK_BIT];
  assign reference_output_select =
    test_reg[tuner_pkg::REFSEL_HI:tuner_pkg::REFSEL_LO]; // [RULE3]

  // Open-drain: only ever pull low; the clock is never stretched.
  assign link.dsda_o    = 1'b0;
  assign link.dsda_oe_n = !drive_low_reg; // [RULE9]
endmodule

// ### hw/tuner_master.sv
// Two-wire bus master driven by byte-level commands over APB.
`timescale 1ns/1ps
module tuner_master #(
  parameter int QTR = tuner_pkg::QTR_CYC
) (
  // System
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Bus pins
  tuner_link_if.master     link
);
  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,
    M_START = 4'h2,
    M_STOP  = 4'h4,
    M_BITS  = 4'h8
  } master_state_t;

  master_state_t           state_reg;
  logic [1:0]              sda_sync_reg;
  logic [15:0]             div_reg;
  logic                    tick;
  logic [1:0]              phase_reg;
  logic [tuner_pkg::CNT_W-1:0] bit_idx_reg;
  logic [8:0]              tx_reg;
  logic [8:0]              rx_reg;
  logic                    is_write_reg;
  logic                    nack_reg;
  logic [7:0]              txd_reg;
  logic [7:0]              rxd_reg;
  logic                    scl_low_reg;
  logic                    sda_low_reg;
  logic                    cmd_wr;
  logic [2:0]              cmd_op;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign cmd_wr  = psel && penable && pwrite &&
                   paddr == tuner_pkg::CMD_OFS && state_reg == M_IDLE;
  assign cmd_op  = pwdata[tuner_pkg::OP_HI:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sync_reg <= 2'h3;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], link.sda};
    end
  end

  // Quarter-period enable keeps the bus clock at or below 400kHz.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else if (state_reg == M_IDLE || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign tick = div_reg == 16'(QTR - 1); // [RULE9]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        tuner_pkg::TXD_OFS:    prdata <= {24'h0, txd_reg};
        tuner_pkg::STATUS_OFS: prdata <= {30'h0, nack_reg,
                                          state_reg != M_IDLE};
        tuner_pkg::RXD_OFS:    prdata <= {24'h0, rxd_reg};
        default:               prdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_reg <= '0;
    end else if (psel && penable && pwrite &&
                 paddr == tuner_pkg::TXD_OFS) begin
      txd_reg <= pwdata[7:0];
    end
  end

  // Each bit: low/set data, rise, sample at high, fall.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= M_IDLE;
      phase_reg    <= '0;
      bit_idx_reg  <= '0;
      tx_reg       <= '1;
      rx_reg       <= '0;
      is_write_reg <= 1'b0;
      nack_reg     <= 1'b0;
      rxd_reg      <= '0;
      scl_low_reg  <= 1'b0;
      sda_low_reg  <= 1'b0;
    end else if (cmd_wr) begin
      phase_reg   <= '0;
      bit_idx_reg <= '0;
      unique case (cmd_op)
        tuner_pkg::OP_START: state_reg <= M_START; // [RULE12]
        tuner_pkg::OP_STOP:  state_reg <= M_STOP; // [RULE12]
        tuner_pkg::OP_WRITE: begin
          state_reg    <= M_BITS;
          is_write_reg <= 1'b1;
          tx_reg       <= {txd_reg, 1'b1}; // [RULE15] [RULE18]
        end
        tuner_pkg::OP_READ: begin
          state_reg    <= M_BITS;
          is_write_reg <= 1'b0;
          tx_reg       <= {8'hff, pwdata[tuner_pkg::NACK_BIT]}; // [RULE21]
        end
        default: ;
      endcase
    end else if (tick) begin
      phase_reg <= phase_reg + 1'b1;
      unique case (state_reg)
        M_START: unique case (phase_reg)
          2'h0: sda_low_reg <= 1'b0;
          2'h1: scl_low_reg <= 1'b0;
          2'h2: sda_low_reg <= 1'b1; // [RULE12]
          2'h3: begin
            scl_low_reg <= 1'b1;
            state_reg   <= M_IDLE;
          end
        endcase
        M_STOP: unique case (phase_reg)
          2'h0: sda_low_reg <= 1'b1;
          2'h1: scl_low_reg <= 1'b0;
          2'h2: sda_low_reg <= 1'b0; // [RULE12]
          2'h3: state_reg   <= M_IDLE;
        endcase
        M_BITS: unique case (phase_reg)
          2'h0: begin
            sda_low_reg <= !tx_reg[8]; // [RULE11] [RULE13] [RULE14]
            tx_reg      <= {tx_reg[7:0], 1'b1};
          end
          2'h1: scl_low_reg <= 1'b0;
          2'h2: rx_reg <= {rx_reg[7:0], sda_sync_reg[1]};
          2'h3: begin
            scl_low_reg <= 1'b1;
            bit_idx_reg <= bit_idx_reg + 1'b1;
            if (bit_idx_reg == tuner_pkg::ACK_SLOT) begin // [RULE10]
              state_reg   <= M_IDLE;
              sda_low_reg <= 1'b0;
              rxd_reg     <= rx_reg[8:1];
              if (is_write_reg) begin
                nack_reg <= rx_reg[0]; // [RULE22]
              end
            end
          end
        endcase
        default: ;
      endcase
    end
  end

  assign link.scl_o     = 1'b0;
  assign link.scl_oe_n  = !scl_low_reg;
  assign link.msda_o    = 1'b0;
  assign link.msda_oe_n = !sda_low_reg;
endmodule

// ### tb/tuner_i2c_status_port_chk.sv
// Protocol checker for the two-wire link between master and tuner port.
`timescale 1ns/1ps
module tuner_i2c_status_port_chk #(
  parameter int QTR = 4
) (
  // System
  input logic pclk,
  input logic presetn,
  // Link
  input logic scl_o,
  input logic scl_oe_n,
  input logic msda_o,
  input logic msda_oe_n,
  input logic dsda_o,
  input logic dsda_oe_n,
  input logic scl,
  input logic sda
);
  logic        scl_q;
  logic        sda_q;
  logic        busy;
  logic [15:0] run;
  logic        start_c;
  logic        stop_c;
  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c  = scl && scl_q && !sda_q && sda;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The run counter saturates so a long idle bus cannot wrap it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy  <= 1'b0;
      run   <= 16'h0000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      busy  <= start_c ? 1'b1 : (stop_c ? 1'b0 : busy);
      run   <= (scl != scl_q) ? 16'h0000 : run + {15'h0, run != 16'hffff};
    end
  end
  dev_stable_a:
    assert property (scl && scl_q |-> $stable(dsda_oe_n))
    else $error("Device data moved while clock high.");
  ack_setup_a:
    assert property ($fell(dsda_oe_n) |-> !scl)
    else $error("Device pulled data low while clock high.");
  nack_release_a:
    assert property ($rose(dsda_oe_n) |-> !scl)
    else $error("Device released data while clock high.");
  ack_hold_a:
    assert property ($rose(scl) && !dsda_oe_n |-> !dsda_oe_n [*6])
    else $error("Device let go of data during the clock pulse.");
  open_drain_a:
    assert property (scl_o == 1'b0 && msda_o == 1'b0 && dsda_o == 1'b0)
    else $error("Open-drain value not low.");
  scl_pace_a:
    assert property (scl != scl_q |-> run >= 16'(2 * QTR - 2))
    else $error("Clock phase shorter than two quarters.");
  ctrl_free_a:
    assert property (start_c || stop_c |-> dsda_oe_n)
    else $error("Device drove data during a start or stop.");
  idle_quiet_a:
    assert property (!busy |-> dsda_oe_n)
    else $error("Device drove data on an idle bus.");
  start_c_cov: cover property (start_c);
  stop_c_cov: cover property (stop_c);
  dev_ack_cov: cover property ($rose(scl) && !dsda_oe_n);
endmodule

// ### tb/tuner_i2c_status_port_tb.sv
// Self-checking bench for the tuner two-wire port and its bus master.
`timescale 1ns/1ps
module tuner_i2c_status_port_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        asuc = 1'b1;
  logic        adone = 1'b1;
  logic        lock = 1'b1;
  logic        strap = 1'b0;
  logic [2:0]  cpt;
  logic [2:0]  refsel;
  logic        fle;
  logic        cv;
  logic [7:0]  ci;
  logic [7:0]  cd;
  logic [7:0]  lidx;
  logic [7:0]  ldat;
  logic [7:0]  q0;
  logic [7:0]  q1;
  logic        nk;
  logic [31:0] st;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [2:0]  cps [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  always #20 pclk = ~pclk;
  tuner_link_if link ();
  tuner_master #(.QTR(4)) tuner_master_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  tuner_slave tuner_slave_inst (.pclk(pclk), .presetn(presetn), .link(link),
    .addr_strap(strap), .autoselect_success(asuc), .autoselect_done(adone),
    .pll_lock_flag(lock), .oscillator_band_readback(5'h13), .tune_code(3'h5),
    .charge_pump_test_select(cpt), .fast_lock_enable(fle),
    .reference_output_select(refsel), .cfg_wr_valid(cv), .cfg_wr_index(ci),
    .cfg_wr_data(cd));
  tuner_i2c_status_port_chk #(.QTR(4)) chk_inst (.pclk(pclk),
    .presetn(presetn), .scl_o(link.scl_o), .scl_oe_n(link.scl_oe_n),
    .msda_o(link.msda_o), .msda_oe_n(link.msda_oe_n), .dsda_o(link.dsda_o),
    .dsda_oe_n(link.dsda_oe_n), .scl(link.scl), .sda(link.sda));
  always @(posedge pclk) begin
    if (cv === 1'b1) begin
      lidx <= ci;
      ldat <= cd;
    end
  end
  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Busy rises on the same edge that takes the command; polling still waits two edges first.
  task automatic op(input logic [3:0] c, output logic [31:0] r);
    apb(1'b1, tuner_pkg::CMD_OFS, {28'h0, c}, r);
    repeat (2) @(posedge pclk);
    r = 32'h1;
    while (r[tuner_pkg::BUSY_BIT] !== 1'b0)
      apb(1'b0, tuner_pkg::STATUS_OFS, 32'h0, r);
  endtask
  task automatic wb(input logic [7:0] b, output logic n);
    logic [31:0] r;
    apb(1'b1, tuner_pkg::TXD_OFS, {24'h0, b}, r);
    op({1'b0, tuner_pkg::OP_WRITE}, r);
    n = r[tuner_pkg::GOTNACK_BIT];
  endtask
  task automatic rb(input logic k, output logic [7:0] b);
    logic [31:0] r;
    op({k, tuner_pkg::OP_READ}, r);
    apb(1'b0, tuner_pkg::RXD_OFS, 32'h0, r);
    b = r[7:0];
  endtask
  task automatic adr(input logic [7:0] ab, output logic n);
    logic [31:0] r;
    op({1'b0, tuner_pkg::OP_START}, r);
    wb(ab, n);
  endtask
  task automatic wr(input logic [7:0] p, d);
    logic n;
    adr(8'hc0, n);
    check("address ack", 8'h00, {7'h0, n});
    wb(p, n);
    wb(d, n);
    check("data ack", 8'h00, {7'h0, n});
    op({1'b0, tuner_pkg::OP_STOP}, st);
  endtask
  task automatic rd(input logic [7:0] p, input logic two,
                    output logic [7:0] a, b);
    logic n;
    adr(8'hc0, n);
    wb(p, n);
    adr(8'hc1, n);
    check("read address ack", 8'h00, {7'h0, n});
    rb(!two, a);
    if (two) rb(1'b1, b);
    op({1'b0, tuner_pkg::OP_STOP}, st);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(tuner_pkg::STAT1_IDX, 1'b1, q0, q1);
    check("status one", 8'he0, q0);
    check("status two", 8'h9d, q1);
    rd(tuner_pkg::STAT1_IDX, 1'b0, q0, q1);
    check("power flag", 8'h60, q0);
    foreach (cps[i]) begin
      wr(tuner_pkg::TEST_IDX, {cps[i], 5'h08});
      check("pump mode", {5'h0, cps[i]}, {5'h0, cpt});
      check("fast lock", 8'h01, {7'h0, fle});
      check("ref select", 8'h00, {5'h0, refsel});
    end
    rd(tuner_pkg::TEST_IDX, 1'b0, q0, q1);
    check("test readback", 8'he8, q0);
    asuc <= 1'b0;
    adone <= 1'b0;
    rd(tuner_pkg::STAT1_IDX, 1'b0, q0, q1);
    check("status search", 8'h10, q0);
    adr(8'hc0, nk);
    wb(8'h0a, nk);
    wb(8'h5a, nk);
    wb(8'h08, nk);
    wb(8'h00, nk);
    check("open write ack", 8'h00, {7'h0, nk});
    check("cfg index", 8'h0a, lidx);
    check("cfg data", 8'h5a, ldat);
    check("next register", 8'h00, {5'h0, cpt});
    op({1'b0, tuner_pkg::OP_STOP}, st);
    adr(8'hc2, nk);
    check("foreign ack", 8'h01, {7'h0, nk});
    op({1'b0, tuner_pkg::OP_STOP}, st);
    // Second power-up with the strap high moves the port to the other pair.
    presetn <= 1'b0;
    strap <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    adr(8'hc2, nk);
    check("strap ack", 8'h00, {7'h0, nk});
    op({1'b0, tuner_pkg::OP_STOP}, st);
    adr(8'hc0, nk);
    check("strap foreign", 8'h01, {7'h0, nk});
    op({1'b0, tuner_pkg::OP_STOP}, st);
    conclude();
  end
  initial begin
    #2400000;
    n_mismatch++;
    conclude();
  end
endmodule
